/* tb_top.sv */
// Self-checking testbench for the timer clock and reset control block.
`timescale 1ns/10ps
module tb_top
  import tcrc_pkg::*;
;
  logic clk, sys_rst, clkEn, watchdogReset, globalIrqEnable, wakeRequest;
  logic int24Tick;
  logic xtalTick = 1'b0, lp32Tick = 1'b0, cpuClockTick = 1'b0;
  logic int24Clock = 1'b0, xtalClock = 1'b0, lp32Clock = 1'b0, cpuClock = 1'b0;
  logic avRead, avWrite, avWaitRequest, clockOutputPin, intervalIrq;
  logic sleepActive, haltActive, int24Enable, cpuClockExternal, cpuRestart;
  logic [7:0] avAddress, rd;
  logic [31:0] avWriteData, avReadData;
  logic [2:0] cpuClockDivide;
  logic [11:0] intervalCount, rl;
  logic [3:0] phase = 4'h0;
  int mismatches = 0, checkCount = 0, cycles = 0, n;

  tcrc_top dut_u (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .watchdogReset(watchdogReset),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest), .int24Tick(int24Tick),
    .xtalTick(xtalTick), .lp32Tick(lp32Tick), .cpuClockTick(cpuClockTick),
    .int24Clock(int24Clock), .xtalClock(xtalClock), .lp32Clock(lp32Clock), .cpuClock(cpuClock),
    .globalIrqEnable(globalIrqEnable), .wakeRequest(wakeRequest),
    .clockOutputPin(clockOutputPin), .intervalIrq(intervalIrq), .sleepActive(sleepActive),
    .haltActive(haltActive), .int24Enable(int24Enable), .cpuClockExternal(cpuClockExternal),
    .cpuClockDivide(cpuClockDivide), .cpuRestart(cpuRestart), .intervalCount(intervalCount));

  tcrc_cpu_model cpu_u (.clk(clk), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData));

  always #10 clk = ~clk;

  // Source ticks at rates 1, 1/2 and 1/4; raw clocks change at random except lp32Clock, which follows phase[3].
  always @(posedge clk)
  begin
    phase <= phase + 4'h1;
    xtalTick <= phase[0];
    lp32Tick <= (phase[1:0] == 2'h3);
    lp32Clock <= phase[3];
    {int24Clock, xtalClock, cpuClock, cpuClockTick} <= 4'($urandom);
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      stopTest();
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checkCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic waitIrq(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (intervalIrq !== 1'b1 && c < 5000);
  endtask

  function automatic logic pinFor(input logic [1:0] s);
    case (s)
      2'h0: pinFor = int24Clock;
      2'h1: pinFor = xtalClock;
      2'h2: pinFor = lp32Clock;
      default: pinFor = cpuClock;
    endcase
  endfunction

  function automatic int periodFor(input int src, input int dv, input logic [11:0] r);
    periodFor = (int'(r) + 1) * (dv + 1) * (src == 0 ? 1 : (src == 1 ? 2 : 4));
  endfunction

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    watchdogReset = 1'b0;
    globalIrqEnable = 1'b0;
    wakeRequest = 1'b0;
    int24Tick = 1'b1;
    void'($urandom(22459));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    cpu_u.busRead(TCRC_ADDR_STATUS, rd);
    check("status reset", 16'h0010, rd);
    cpu_u.busRead(TCRC_ADDR_TIMER_CLOCK, rd);
    check("timer cfg reset", 16'h000C, rd);
    check("cpu divide", 16'h0007, cpuClockDivide);
    check("cpu external", 16'h0000, cpuClockExternal);
    cpu_u.busWrite(TCRC_ADDR_CLOCK_OUT, 8'hFF);
    cpu_u.busRead(TCRC_ADDR_CLOCK_OUT, rd);
    check("clock out reserved", 16'h0003, rd);
    cpu_u.busWrite(8'h50, 8'hA5);
    cpu_u.busRead(8'h50, rd);
    check("unmapped", 16'h0000, rd);
    for (int s = 0; s < 4; s++)
    begin
      cpu_u.busWrite(TCRC_ADDR_CLOCK_OUT, 8'(s));
      for (int k = 0; k < 4; k++)
      begin
        do @(posedge clk); while (phase[2:0] !== 3'h6);
        check("clock pin", 16'(pinFor(2'(s))), 16'(clockOutputPin));
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      rl = (i == 5) ? 12'h100 : 12'(2 + $urandom % 30);
      cpu_u.writeReload(rl);
      cpu_u.busWrite(TCRC_ADDR_TIMER_CLOCK, 8'h30 | 8'((i < 3 ? 0 : i - 2) << 2) | 8'(i < 3 ? i : 0));
      waitIrq(n);
      waitIrq(n);
      check("irq period", 16'(periodFor(i < 3 ? i : 0, i < 3 ? 0 : i - 2, rl)), 16'(n));
      check("count bound", 16'h0001, 16'(intervalCount <= rl));
      @(posedge clk);
      check("irq pulse", 16'h0000, 16'(intervalIrq));
    end
    for (int cd = 0; cd < 4; cd++)
    begin
      rl = 12'(2 + $urandom % 30);
      cpu_u.writeReload(rl);
      cpu_u.busWrite(TCRC_ADDR_TIMER_CLOCK, 8'(cd << 6) | 8'((cd % 3) << 4) | 8'h03);
      waitIrq(n);
      waitIrq(n);
      check("capture period", 16'(periodFor(cd % 3, 2 * cd + 1, rl)), 16'(n));
    end
    globalIrqEnable <= 1'b1;
    cpu_u.busRead(TCRC_ADDR_STATUS, rd);
    check("gie mirror", 16'h0090, rd);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h00);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h10);
    cpu_u.busRead(TCRC_ADDR_STATUS, rd);
    check("por clear only", 16'h0080, rd);
    globalIrqEnable <= 1'b0;
    watchdogReset <= 1'b1;
    @(posedge clk);
    check("restart", 16'h0001, cpuRestart);
    watchdogReset <= 1'b0;
    @(posedge clk);
    cpu_u.busRead(TCRC_ADDR_STATUS, rd);
    check("wdr flag", 16'h0020, rd);
    cpu_u.busRead(TCRC_ADDR_CLOCK_OUT, rd);
    check("wdr defaults", 16'h0000, rd);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h00);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h20);
    cpu_u.busRead(TCRC_ADDR_STATUS, rd);
    check("wdr clear only", 16'h0000, rd);
    cpu_u.busWrite(TCRC_ADDR_CLOCK_OUT, 8'h02);
    cpu_u.busWrite(TCRC_ADDR_CPU_CLOCK, 8'h01);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h08);
    @(posedge clk);
    check("sleep", 16'h0001, sleepActive);
    check("sleep cpu sel", 16'h0000, cpuClockExternal);
    check("sleep pin", 16'h0000, clockOutputPin);
    check("sleep osc", 16'h0000, int24Enable);
    wakeRequest <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sleepActive !== 1'b0 && n < 200);
    check("wake time", 16'h0001, 16'(n >= 30 && n <= 100));
    @(posedge clk);
    check("wake cpu sel", 16'h0000, cpuClockExternal);
    check("wake osc", 16'h0001, int24Enable);
    wakeRequest <= 1'b0;
    cpu_u.busWrite(TCRC_ADDR_CPU_CLOCK, 8'h01);
    check("reselect", 16'h0001, cpuClockExternal);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h01);
    cpu_u.busWrite(TCRC_ADDR_STATUS, 8'h00);
    check("halt", 16'h0001, haltActive);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("halt reset", 16'h0000, haltActive);
    cpu_u.busRead(TCRC_ADDR_STATUS, rd);
    check("status again", 16'h0010, rd);
    stopTest();
  end
endmodule

/* tcrc_cpu_model.sv */
// CPU-side model: firmware bus master for the register interface.
`timescale 1ns/10ps
module tcrc_cpu_model
  import tcrc_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] avReadData,
  input wire logic avWaitRequest,
  output logic [7:0] avAddress,
  output logic avRead,
  output logic avWrite,
  output logic [31:0] avWriteData
);
  initial
  begin
    avAddress = 8'h00;
    avRead = 1'b0;
    avWrite = 1'b0;
    avWriteData = 32'h0000_0000;
  end

  // Write one byte; the request stands until waitrequest is seen low.
  task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
    avAddress <= a;
    avWriteData <= {24'h00_0000, d};
    avWrite <= 1'b1;
    do @(posedge clk); while (avWaitRequest !== 1'b0);
    avWrite <= 1'b0;
    @(posedge clk);
  endtask

  // Read one byte; data is taken at the edge where waitrequest is low.
  task automatic busRead(input logic [7:0] a, output logic [7:0] d);
    avAddress <= a;
    avRead <= 1'b1;
    do @(posedge clk); while (avWaitRequest !== 1'b0);
    d = avReadData[7:0];
    avRead <= 1'b0;
    @(posedge clk);
  endtask

  // Reload is written low byte first, then the high bits back to back.
  task automatic writeReload(input logic [11:0] v);
    busWrite(TCRC_ADDR_RELOAD_LO, v[7:0]);
    busWrite(TCRC_ADDR_RELOAD_HI, {4'h0, v[11:8]});
  endtask
endmodule

/* tcrc_pkg.sv */
// Package with register map, field positions, reset values and timing counts.
package tcrc_pkg;
  localparam logic [7:0] TCRC_ADDR_TIMER_CLOCK = 8'h31;
  localparam logic [7:0] TCRC_ADDR_CLOCK_OUT = 8'h32;
  localparam logic [7:0] TCRC_ADDR_RELOAD_LO = 8'h40;
  localparam logic [7:0] TCRC_ADDR_RELOAD_HI = 8'h41;
  localparam logic [7:0] TCRC_ADDR_COUNT_LO = 8'h42;
  localparam logic [7:0] TCRC_ADDR_COUNT_HI = 8'h43;
  localparam logic [7:0] TCRC_ADDR_CPU_CLOCK = 8'h44;
  localparam logic [7:0] TCRC_ADDR_STATUS = 8'hFF;
  localparam logic [7:0] TCRC_TIMER_CLOCK_RESET = 8'h0C;
  localparam logic [7:0] TCRC_CLOCK_OUT_RESET = 8'h00;
  localparam logic [7:0] TCRC_STATUS_POR = 8'h10;
  localparam logic [7:0] TCRC_CPU_CLOCK_RESET = 8'h00;
  localparam int TCRC_BIT_GLOBAL_IRQ_ENABLE_MIRROR = 7;
  localparam int TCRC_BIT_WATCHDOG_RESET_FLAG = 5;
  localparam int TCRC_BIT_POWER_ON_RESET_FLAG = 4;
  localparam int TCRC_BIT_SLEEP = 3;
  localparam int TCRC_BIT_STOP = 0;
  localparam int TCRC_BIT_CPU_SELECT = 0;
  localparam logic [2:0] TCRC_CPU_DIV_RESET = 3'h7;
  localparam logic [1:0] TCRC_SRC_INT24 = 2'h0;
  localparam logic [1:0] TCRC_SRC_XTAL = 2'h1;
  localparam logic [1:0] TCRC_SRC_LP32 = 2'h2;
  localparam logic [1:0] TCRC_SRC_OTHER = 2'h3;
  localparam int TCRC_RELOAD_WIDTH = 12;
  localparam int TCRC_WAKE_LP_CYCLES = 3;
  typedef enum logic [1:0] {TCRC_SEL_INT24, TCRC_SEL_XTAL, TCRC_SEL_LP32, TCRC_SEL_CPU} tcrc_sel_t;
endpackage

/* tcrc_prescaler.sv */
// Source selector and programmable prescaler producing a one-cycle tick.
`timescale 1ns/10ps
module tcrc_prescaler
  import tcrc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  tcrc_tick_if.div tp
);
  logic [3:0] divCount;
  logic srcEvent;

  // The selected source edge counts toward the divide limit.
  assign srcEvent = tp.srcTick[tp.srcSel];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      divCount <= 4'h0;
      tp.tick <= 1'b0;
    end
    else if (clkEn)
    begin
      tp.tick <= 1'b0;
      if (srcEvent)
      begin
        if (divCount >= tp.divLimit)
        begin
          divCount <= 4'h0;
          tp.tick <= 1'b1;
        end
        else
        begin
          divCount <= divCount + 4'h1;
        end
      end
    end
  end
endmodule

/* tcrc_tick_if.sv */
// Interface carrying one prescaled tick stream between the top and the prescaler.
`timescale 1ns/10ps
interface tcrc_tick_if;
  logic [3:0] srcTick;
  logic [1:0] srcSel;
  logic [3:0] divLimit;
  logic tick;
  modport ctrl (output srcTick, output srcSel, output divLimit, input tick);
  modport div (input srcTick, input srcSel, input divLimit, output tick);
endinterface

/* tcrc_top.sv */
// Timer clocks, interval timer, clock output select and system status control.
`timescale 1ns/10ps
// Operation
// - Interval tick source: crystal, 24 MHz, 32 kHz (not in sleep), or capture tick.
// - Interval tick source is divided by one, two, three or four.
// - Interval timer is a 12-bit down counter with separate reload register.
// - The tick after reaching zero loads the reload value instead of counting.
// - Each reload raises an interrupt request pulse to the CPU.
// - Capture tick source: crystal, 24 MHz or 32 kHz, the latter not in sleep.
// - Capture tick source is divided by two, four, six or eight.
// - Clock output select: 00 24 MHz, 01 crystal, 10 32 kHz, 11 CPU clock.
// - The 32 kHz clock output selection is not used during sleep.
// - Entering sleep forces CPU clock to internal oscillator and stops it.
// - After sleep the CPU runs internally once three 32 kHz cycles pass.
// - Power-on or watchdog reset restores defaults and disables interrupts; the block only mirrors the globalIrqEnable input and does not clear it.
// - Separate status flags record power-on and watchdog reset causes.
// - After reset execution restarts at zero in internal clocking mode.
// - Power-on CPU clock is the 24 MHz oscillator divided by eight.
// - Power-on reset loads the status register with only bit 4 set.
// - Power-on flag is set by hardware only; firmware may clear it.
// - Setting the sleep bit puts the CPU to sleep.
module tcrc_top
  import tcrc_pkg::*;
#(
  parameter int RELOAD_WIDTH = TCRC_RELOAD_WIDTH
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic watchdogReset,
  input wire logic [7:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  input wire logic int24Tick,
  input wire logic xtalTick,
  input wire logic lp32Tick,
  input wire logic cpuClockTick,
  input wire logic int24Clock,
  input wire logic xtalClock,
  input wire logic lp32Clock,
  input wire logic cpuClock,
  input wire logic globalIrqEnable,
  input wire logic wakeRequest,
  output logic clockOutputPin,
  output logic intervalIrq,
  output logic sleepActive,
  output logic haltActive,
  output logic int24Enable,
  output logic cpuClockExternal,
  output logic [2:0] cpuClockDivide,
  output logic cpuRestart,
  output logic [RELOAD_WIDTH-1:0] intervalCount
);
  logic [7:0] timerClockConfig;
  logic [1:0] clockOutSelect;
  logic [RELOAD_WIDTH-1:0] intervalReload;
  logic cpuSelect;
  logic watchdogFlag;
  logic powerOnFlag;
  logic sleepBit;
  logic stopBit;
  logic [1:0] wakeSync;
  logic [1:0] lpSync;
  logic lpSeen;
  logic [1:0] wakeCount;
  logic waking;
  logic intervalTick;
  logic captureTick;
  logic rdPending;
  logic [31:0] next_readData;
  logic wrStrobe;
  logic [7:0] wrByte;
  logic lpEdge;

  tcrc_tick_if captureIf ();
  tcrc_tick_if intervalIf ();

  // Capture tick: selectable source, divide by two to eight in steps of two.
  assign captureIf.srcTick = {1'b0, sleepActive ? 1'b0 : lp32Tick, xtalTick, int24Tick};
  assign captureIf.srcSel = timerClockConfig[5:4];
  assign captureIf.divLimit = {1'b0, timerClockConfig[7:6], 1'b1};
  assign captureTick = captureIf.tick;

  // Interval tick: selectable source including the capture tick, divide one to four.
  assign intervalIf.srcTick = {captureTick, sleepActive ? 1'b0 : lp32Tick, xtalTick,
    int24Tick};
  assign intervalIf.srcSel = timerClockConfig[1:0];
  assign intervalIf.divLimit = {2'b00, timerClockConfig[3:2]};
  assign intervalTick = intervalIf.tick;

  tcrc_prescaler uCapture (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .tp(captureIf)
  );

  tcrc_prescaler uInterval (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .tp(intervalIf)
  );

  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] target);
    regHit = (addr == target);
  endfunction

  // Writes take effect on the edge where waitrequest is low; reads wait one cycle.
  assign avWaitRequest = (avRead && !rdPending) || ((avRead || avWrite) && !clkEn);
  assign wrStrobe = avWrite && clkEn;
  assign wrByte = avWriteData[7:0];

  always_ff @(posedge clk)
  begin
    if (sys_rst || watchdogReset)
    begin
      timerClockConfig <= TCRC_TIMER_CLOCK_RESET;
      clockOutSelect <= TCRC_CLOCK_OUT_RESET[1:0];
      intervalReload <= '0;
      cpuSelect <= TCRC_CPU_CLOCK_RESET[0];
      cpuClockDivide <= TCRC_CPU_DIV_RESET;
    end
    else if (wrStrobe)
    begin
      if (regHit(avAddress, TCRC_ADDR_TIMER_CLOCK))
        timerClockConfig <= wrByte;
      if (regHit(avAddress, TCRC_ADDR_CLOCK_OUT))
        clockOutSelect <= wrByte[1:0];
      if (regHit(avAddress, TCRC_ADDR_RELOAD_LO))
        intervalReload[7:0] <= wrByte;
      if (regHit(avAddress, TCRC_ADDR_RELOAD_HI))
        intervalReload[RELOAD_WIDTH-1:8] <= wrByte[RELOAD_WIDTH-9:0];
      if (regHit(avAddress, TCRC_ADDR_CPU_CLOCK))
      begin
        cpuSelect <= wrByte[TCRC_BIT_CPU_SELECT];
        cpuClockDivide <= wrByte[3:1];
      end
    end
    else if (clkEn && sleepActive)
    begin
      cpuSelect <= 1'b0;
    end
  end

  // Reset cause flags and sleep and stop controls.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      powerOnFlag <= TCRC_STATUS_POR[TCRC_BIT_POWER_ON_RESET_FLAG];
      watchdogFlag <= TCRC_STATUS_POR[TCRC_BIT_WATCHDOG_RESET_FLAG];
      sleepBit <= 1'b0;
      stopBit <= 1'b0;
    end
    else if (watchdogReset)
    begin
      watchdogFlag <= 1'b1;
      powerOnFlag <= 1'b0;
      sleepBit <= 1'b0;
      stopBit <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrStrobe && regHit(avAddress, TCRC_ADDR_STATUS))
      begin
        powerOnFlag <= powerOnFlag & wrByte[TCRC_BIT_POWER_ON_RESET_FLAG];
        watchdogFlag <= watchdogFlag & wrByte[TCRC_BIT_WATCHDOG_RESET_FLAG];
        sleepBit <= wrByte[TCRC_BIT_SLEEP];
        stopBit <= stopBit | wrByte[TCRC_BIT_STOP];
      end
      else if (waking && wakeCount == 2'(TCRC_WAKE_LP_CYCLES))
      begin
        sleepBit <= 1'b0;
      end
    end
  end

  // Wake request and 32 kHz clock sampling, then a three cycle recovery count.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wakeSync <= 2'b00;
      lpSync <= 2'b00;
      lpSeen <= 1'b0;
    end
    else if (clkEn)
    begin
      wakeSync <= {wakeSync[0], wakeRequest};
      lpSync <= {lpSync[0], lp32Clock};
      lpSeen <= lpSync[1];
    end
  end

  assign lpEdge = lpSync[1] && !lpSeen;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      waking <= 1'b0;
      wakeCount <= 2'b00;
    end
    else if (clkEn)
    begin
      if (!sleepBit)
      begin
        waking <= 1'b0;
        wakeCount <= 2'b00;
      end
      else if (wakeSync[1])
      begin
        waking <= 1'b1;
      end
      if (sleepBit && waking && lpEdge && wakeCount != 2'(TCRC_WAKE_LP_CYCLES))
        wakeCount <= wakeCount + 2'b01;
    end
  end

  assign sleepActive = sleepBit;
  assign haltActive = stopBit || sleepBit;
  assign int24Enable = !sleepBit || waking;
  assign cpuClockExternal = cpuSelect;
  assign cpuRestart = sys_rst || watchdogReset;

  // Interval down counter with reload on the tick after zero.
  always_ff @(posedge clk)
  begin
    if (sys_rst || watchdogReset)
    begin
      intervalCount <= '0;
      intervalIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      intervalIrq <= 1'b0;
      if (intervalTick)
      begin
        if (intervalCount == '0)
        begin
          intervalCount <= intervalReload;
          intervalIrq <= 1'b1;
        end
        else
        begin
          intervalCount <= intervalCount - RELOAD_WIDTH'(1);
        end
      end
    end
  end

  // Clock output routing; the low-power choice is blanked in sleep.
  always_comb
  begin
    unique case (tcrc_sel_t'(clockOutSelect))
      TCRC_SEL_INT24: clockOutputPin = int24Clock;
      TCRC_SEL_XTAL: clockOutputPin = xtalClock;
      TCRC_SEL_LP32: clockOutputPin = sleepActive ? 1'b0 : lp32Clock;
      TCRC_SEL_CPU: clockOutputPin = cpuClock;
    endcase
  end

  always_comb
  begin
    next_readData = 32'h0000_0000;
    unique case (avAddress)
      TCRC_ADDR_TIMER_CLOCK: next_readData[7:0] = timerClockConfig;
      TCRC_ADDR_CLOCK_OUT: next_readData[1:0] = clockOutSelect;
      TCRC_ADDR_RELOAD_LO: next_readData[7:0] = intervalReload[7:0];
      TCRC_ADDR_RELOAD_HI: next_readData[RELOAD_WIDTH-9:0] = intervalReload[RELOAD_WIDTH-1:8];
      TCRC_ADDR_COUNT_LO: next_readData[7:0] = intervalCount[7:0];
      TCRC_ADDR_COUNT_HI: next_readData[RELOAD_WIDTH-9:0] = intervalCount[RELOAD_WIDTH-1:8];
      TCRC_ADDR_CPU_CLOCK: next_readData[3:0] = {cpuClockDivide, cpuSelect};
      TCRC_ADDR_STATUS:
      begin
        next_readData[TCRC_BIT_GLOBAL_IRQ_ENABLE_MIRROR] = globalIrqEnable;
        next_readData[TCRC_BIT_WATCHDOG_RESET_FLAG] = watchdogFlag;
        next_readData[TCRC_BIT_POWER_ON_RESET_FLAG] = powerOnFlag;
        next_readData[TCRC_BIT_SLEEP] = sleepBit;
        next_readData[TCRC_BIT_STOP] = stopBit;
      end
      default: next_readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      avReadData <= 32'h0000_0000;
      rdPending <= 1'b0;
    end
    else if (clkEn)
    begin
      rdPending <= avRead && !rdPending;
      if (avRead && !rdPending)
        avReadData <= next_readData;
    end
  end

  a_reload_irq_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && intervalTick && intervalCount == '0 && !watchdogReset) |=> intervalIrq)
    else $error("Reload did not raise interrupt.");
  a_reload_loads_value: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && intervalTick && intervalCount == '0 && !watchdogReset)
    |=> intervalCount == $past(intervalReload))
    else $error("Reload value not loaded.");
  a_count_steps_down: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && intervalTick && intervalCount != '0 && !watchdogReset)
    |=> intervalCount == $past(intervalCount) - 1'b1)
    else $error("Counter did not decrement.");
  a_por_status_value: assert property (@(posedge clk)
    $fell(sys_rst) |-> powerOnFlag && !watchdogFlag && !sleepBit && !stopBit)
    else $error("Status not at power-on value.");
  a_por_clear_only: assert property (@(posedge clk) disable iff (sys_rst)
    !powerOnFlag |=> !powerOnFlag)
    else $error("Power-on flag set by firmware.");
  a_wdr_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    watchdogReset |=> watchdogFlag && !powerOnFlag)
    else $error("Watchdog flag not recorded.");
  a_sleep_forces_int: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && sleepActive && !wrStrobe) |=> !cpuClockExternal)
    else $error("Sleep did not force internal clock.");
  a_stop_holds_halt: assert property (@(posedge clk) disable iff (sys_rst)
    (stopBit && !watchdogReset) |=> stopBit && haltActive)
    else $error("Halt released without reset.");
  a_lp_out_blank: assert property (@(posedge clk) disable iff (sys_rst)
    (clockOutSelect == TCRC_SRC_LP32 && sleepActive) |-> !clockOutputPin)
    else $error("Low-power clock output during sleep.");
endmodule
